// ### sio_core.sv
// Safety request decode, acknowledge outputs and register port
`timescale 1ns/1ps
module sio_core
    import sio_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_we,
    input  wire logic                reg_re,
    output logic [DATA_W-1:0]        reg_rdata,
    output logic                     irq,
    // Safety controller side, all active low
    input  wire logic [NUM_REQ-1:0]  request_in_n,
    input  wire logic                controlled_first_stop_n,
    input  wire logic                redundant_stop_and_clear_n,
    // Motion monitor and host status
    input  wire logic                supply_ok,
    input  wire logic                internal_err,
    input  wire logic                major_err,
    input  wire logic                limit_exceeded,
    input  wire logic                ramp_done,
    input  wire logic                standstill_ok,
    input  wire logic                direction_ok,
    input  wire logic                range_ok,
    input  wire logic                torque_ack_fb,
    input  wire logic                brake_cmd_in,
    // Outputs to controller and host
    output logic [NUM_FUNC-1:0]      func_active,
    output logic [NUM_REQ-1:0]       func_trigger,
    output logic                     torque_removal_ack,
    output logic                     second_shutdown_route,
    output logic                     ready,
    output logic                     halt_ack,
    output logic                     dir_ack,
    output logic                     range_ack,
    output logic [NUM_STAT-1:0]      status_out,
    output logic                     pulse_disable,
    output logic                     brake_cmd_out
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    localparam int SYN_W = NUM_REQ + 2;

    logic [SYN_W-1:0] syn1_ff;
    logic [SYN_W-1:0] syn2_ff;
    logic [SYN_W-1:0] prev_ff;
    wire  [SYN_W-1:0] raw_in = {redundant_stop_and_clear_n,
                                controlled_first_stop_n, request_in_n};

    // Two stages, then a copy for edge detection; stage one feeds
    // only stage two
    always_ff @(posedge core_clk) begin
        if (rst) begin
            syn1_ff <= '1;
            syn2_ff <= '1;
            prev_ff <= '1;
        end else begin
            syn1_ff <= raw_in;
            syn2_ff <= syn1_ff;
            prev_ff <= syn2_ff;
        end
    end

    wire [NUM_REQ-1:0] req_lvl_n = syn2_ff[NUM_REQ-1:0];
    wire               fs_n      = syn2_ff[NUM_REQ];
    wire               rsc_n     = syn2_ff[NUM_REQ+1];
    // One-cycle pulse per falling edge
    wire [SYN_W-1:0]   fall      = prev_ff & ~syn2_ff;
    wire               rsc_rise  = ~prev_ff[NUM_REQ+1] & rsc_n;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0]          ctrl_ff;
    logic [NUM_REQ*MAP_W-1:0]   in_map_ff;
    logic [NUM_STAT*OSEL_W-1:0] out_map_ff;
    logic [IRQ_W-1:0]           irq_stat_ff;
    logic [IRQ_W-1:0]           irq_mask_ff;
    logic [DATA_W-1:0]          reg_rdata_ff;

    wire wr_ctrl  = reg_we && reg_addr == REG_CTRL;
    wire wr_inmap = reg_we && reg_addr == REG_IN_MAP;
    wire wr_omap  = reg_we && reg_addr == REG_OUT_MAP;
    wire wr_istat = reg_we && reg_addr == REG_IRQ_STAT;
    wire wr_imask = reg_we && reg_addr == REG_IRQ_MASK;

    // Configuration writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_ff     <= CTRL_RST;
            in_map_ff   <= IN_MAP_RST;
            out_map_ff  <= OUT_MAP_RST;
            irq_mask_ff <= '0;
        end else begin
            if (wr_ctrl)
                ctrl_ff <= reg_wdata;
            if (wr_inmap)
                in_map_ff <= reg_wdata[NUM_REQ*MAP_W-1:0];
            if (wr_omap)
                out_map_ff <= reg_wdata[NUM_STAT*OSEL_W-1:0];
            if (wr_imask)
                irq_mask_ff <= reg_wdata[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic [NUM_FUNC-1:0] hit [NUM_REQ];

    // Each input drives the one activation its map field names;
    // codes above the last function give the input no activation
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
            wire [MAP_W-1:0] code = in_map_ff[gi*MAP_W +: MAP_W];
            wire [15:0]      dec  = 16'h0001 << code;
            assign hit[gi] = dec[NUM_FUNC-1:0]
                             & {NUM_FUNC{~req_lvl_n[gi]}};
        end
    endgenerate

    logic [NUM_FUNC-1:0] req_or;

    // OR of all inputs mapped to each activation
    always_comb begin
        req_or = '0;
        for (int i = 0; i < NUM_REQ; i++)
            req_or = req_or | hit[i];
    end

    // ------------------------------------------------------------
    // Operating state and error latch
    // ------------------------------------------------------------
    sio_state_e           state_ff;
    sio_state_e           nxt_state;
    logic [STARTUP_W-1:0] start_cnt_ff;
    logic                 err_ff;
    logic                 fb_fault_ff;
    logic                 torque_ack_ff;

    wire start_done = start_cnt_ff == STARTUP_W'(STARTUP_CYC - 1);
    // Either fixed input low starts the first stop
    wire fs_req     = ~fs_n | ~rsc_n;
    // Both fixed inputs falling together skip the ramp
    wire both_fall  = fall[NUM_REQ] & fall[NUM_REQ+1];
    wire err_event  = internal_err | limit_exceeded | both_fall
                      | (fs_req & limit_exceeded);
    // Clear only on a release of the redundant input with the
    // cause gone; a held fault keeps the card off
    wire err_clear  = rsc_rise & fs_n & ~internal_err & ~limit_exceeded;

    // State transitions
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SIO_START: if (start_done) nxt_state = SIO_RUN;
            SIO_RUN: begin
                if (err_event)
                    nxt_state = SIO_OFF;
                else if (fs_req)
                    nxt_state = SIO_STOP;
            end
            SIO_STOP: begin
                if (err_event || ramp_done)
                    nxt_state = SIO_OFF;
            end
            SIO_OFF: begin
                if (err_clear && !fs_req)
                    nxt_state = SIO_RUN;
            end
            default: nxt_state = SIO_START;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff     <= SIO_START;
            start_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (!start_done)
                start_cnt_ff <= start_cnt_ff + 1'b1;
        end
    end

    // Error latch; a new error beats a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (rst)
            err_ff <= 1'b0;
        else if (err_event)
            err_ff <= 1'b1;
        else if (err_clear)
            err_ff <= 1'b0;
    end

    // Torque-off when off for any reason, or start-up
    always_ff @(posedge core_clk) begin
        if (rst)
            torque_ack_ff <= 1'b1;
        else
            torque_ack_ff <= nxt_state != SIO_RUN
                             && nxt_state != SIO_STOP;
    end

    // Feedback must match the driven level in the same cycle;
    // a mismatch is sticky until the card is cleared
    always_ff @(posedge core_clk) begin
        if (rst)
            fb_fault_ff <= 1'b0;
        else if (torque_ack_fb != torque_removal_ack)
            fb_fault_ff <= 1'b1;
        else if (err_clear)
            fb_fault_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Activations and acknowledges
    // ------------------------------------------------------------
    // Nothing else is processed while the first stop runs
    wire gate_on = state_ff == SIO_RUN && !fs_req;
    wire [NUM_FUNC-1:0] act = req_or & {NUM_FUNC{gate_on}};

    wire mon_halt  = act[FN_SECOND_STOP] | act[FN_OPER_STOP]
                     | act[FN_INCR] | act[FN_BRAKE];
    wire mon_dir   = act[FN_DIR_NEG] | act[FN_DIR_POS];
    wire mon_range = act[FN_SPEED_WIN] | act[FN_SPEED_CEIL]
                     | act[FN_INCR] | act[FN_POSN];

    wire halt_d  = mon_halt & standstill_ok;
    wire dir_d   = mon_dir & direction_ok;
    wire range_d = mon_range & range_ok;
    wire [3:0] src = {1'b0, range_d, dir_d, halt_d};

    logic [NUM_STAT-1:0] stat_d;

    // Output map picks one of the three acknowledges or off
    generate
        for (gi = 0; gi < NUM_STAT; gi++) begin : g_out
            wire [OSEL_W-1:0] sel = out_map_ff[gi*OSEL_W +: OSEL_W];
            assign stat_d[gi] = src[sel];
        end
    endgenerate

    wire ready_d = state_ff != SIO_START && supply_ok && !major_err
                   && !fb_fault_ff;
    wire [NUM_REQ-1:0] trig_d = gate_on ? fall[NUM_REQ-1:0] : '0;

    logic [NUM_FUNC-1:0] func_active_ff;
    logic [NUM_REQ-1:0]  func_trigger_ff;
    logic [NUM_STAT-1:0] status_out_ff;
    logic                halt_ack_ff;
    logic                dir_ack_ff;
    logic                range_ack_ff;
    logic                ready_ff;
    logic                route_ff;
    logic                brake_ff;

    // Output flops; safe levels during reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            func_active_ff  <= '0;
            func_trigger_ff <= '0;
            status_out_ff   <= '0;
            halt_ack_ff     <= 1'b0;
            dir_ack_ff      <= 1'b0;
            range_ack_ff    <= 1'b0;
            ready_ff        <= 1'b0;
            route_ff        <= 1'b0;
            brake_ff        <= 1'b0;
        end else begin
            func_active_ff  <= act;
            func_trigger_ff <= trig_d;
            status_out_ff   <= stat_d;
            halt_ack_ff     <= halt_d;
            dir_ack_ff      <= dir_d;
            range_ack_ff    <= range_d;
            ready_ff        <= ready_d;
            route_ff        <= ctrl_ff[CTRL_ROUTE];
            brake_ff        <= brake_cmd_in;
        end
    end

    assign func_active           = func_active_ff;
    assign func_trigger          = func_trigger_ff;
    assign status_out            = status_out_ff;
    assign halt_ack              = halt_ack_ff;
    assign dir_ack               = dir_ack_ff;
    assign range_ack             = range_ack_ff;
    assign ready                 = ready_ff;
    assign second_shutdown_route = route_ff;
    assign brake_cmd_out         = brake_ff;
    assign torque_removal_ack    = torque_ack_ff;
    // Disabler follows the torque-off acknowledge, high in the start-up and off states
    assign pulse_disable         = torque_ack_ff;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [IRQ_W-1:0] irq_set = {trig_d, fb_fault_ff, err_ff,
                                state_ff == SIO_STOP};

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge core_clk) begin
        if (rst)
            irq_stat_ff <= '0;
        else if (wr_istat)
            irq_stat_ff <= (irq_stat_ff & ~reg_wdata[IRQ_W-1:0])
                           | irq_set;
        else
            irq_stat_ff <= irq_stat_ff | irq_set;
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    wire [DATA_W-1:0] state_word = {
        14'h0000, status_out_ff, ready_ff, route_ff, torque_ack_ff,
        state_ff, func_active_ff
    };

    logic [DATA_W-1:0] rd_mux;

    // Unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            REG_CTRL:     rd_mux = ctrl_ff;
            REG_IN_MAP:   rd_mux = {4'h0, in_map_ff};
            REG_OUT_MAP:  rd_mux = {24'h000000, out_map_ff};
            REG_STATE:    rd_mux = state_word;
            REG_IRQ_STAT: rd_mux = {22'h000000, irq_stat_ff};
            REG_IRQ_MASK: rd_mux = {22'h000000, irq_mask_ff};
            default:      rd_mux = '0;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst)
            reg_rdata_ff <= '0;
        else
            reg_rdata_ff <= reg_re ? rd_mux : '0;
    end

    assign reg_rdata = reg_rdata_ff;

endmodule : sio_core

// ### sio_core_properties.sv
// Concurrent port checks for the safety signalling core
`timescale 1ns/1ps
module sio_core_props
    import sio_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_we,
    input wire logic                reg_re,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic                controlled_first_stop_n,
    input wire logic                supply_ok,
    input wire logic                internal_err,
    input wire logic                major_err,
    input wire logic                standstill_ok,
    input wire logic                range_ok,
    input wire logic                torque_ack_fb,
    input wire logic                brake_cmd_in,
    input wire logic [NUM_FUNC-1:0] func_active,
    input wire logic [NUM_REQ-1:0]  func_trigger,
    input wire logic                torque_removal_ack,
    input wire logic                second_shutdown_route,
    input wire logic                ready,
    input wire logic                halt_ack,
    input wire logic                range_ack,
    input wire logic                pulse_disable,
    input wire logic                brake_cmd_out
);
    // ------------------------------------------------------------
    // Properties, all on the core clock
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Long enough for the two sync stages and the output flop
    sequence s_stop_held;
        !controlled_first_stop_n [*4];
    endsequence
    sequence s_still_lost;
        !standstill_ok [*4];
    endsequence
    sequence s_range_lost;
        !range_ok [*4];
    endsequence
    sequence s_route_wr;
        reg_we && reg_addr == REG_CTRL;
    endsequence

    property p_rdata_idle;
        !$past(reg_re) |-> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_pulse_eq;
        pulse_disable == torque_removal_ack;
    endproperty
    a_pulse_eq: assert property (p_pulse_eq) else $error("disabler differs");
    property p_brake;
        !$past(rst) |-> brake_cmd_out == $past(brake_cmd_in);
    endproperty
    a_brake: assert property (p_brake) else $error("brake not forwarded");
    property p_stop_blocks;
        s_stop_held |-> func_active == '0;
    endproperty
    a_stop_blocks: assert property (p_stop_blocks) else $error("active in stop");
    property p_err_off;
        $rose(internal_err) |-> ##[1:8] torque_removal_ack;
    endproperty
    a_err_off: assert property (p_err_off) else $error("power not removed");
    property p_ready_drop;
        (major_err || !supply_ok) |-> ##[1:6] !ready;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high");
    property p_fb_fault;
        torque_ack_fb != torque_removal_ack |-> ##[1:6] !ready;
    endproperty
    a_fb_fault: assert property (p_fb_fault) else $error("feedback fault missed");
    property p_halt;
        s_still_lost |-> !halt_ack;
    endproperty
    a_halt: assert property (p_halt) else $error("halt ack without standstill");
    property p_range;
        s_range_lost |-> !range_ack;
    endproperty
    a_range: assert property (p_range) else $error("range ack outside limits");
    property p_route;
        s_route_wr |-> ##2 second_shutdown_route == $past(reg_wdata[CTRL_ROUTE], 2);
    endproperty
    a_route: assert property (p_route) else $error("route output wrong");
    property p_trig_one;
        |func_trigger |=> (func_trigger & $past(func_trigger)) == '0;
    endproperty
    a_trig_one: assert property (p_trig_one) else $error("trigger too long");
endmodule : sio_core_props

bind sio_core sio_core_props chk_u (.*);

// ### sio_ctrl_model.sv
// Behavioural safety controller on the card's request and feedback pins
`timescale 1ns/1ps
module sio_ctrl_model
    import sio_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic [NUM_REQ-1:0] req,
    input  wire logic               fstop,
    input  wire logic               rstop,
    input  wire logic               fb_break,
    input  wire logic               torque_removal_ack,
    output logic      [NUM_REQ-1:0] request_in_n,
    output logic                    controlled_first_stop_n,
    output logic                    redundant_stop_and_clear_n,
    output logic                    torque_ack_fb
);
    // ------------------------------------------------------------
    // Registered, always driven request lines
    // ------------------------------------------------------------
    logic [NUM_REQ-1:0] req_n_ff   = '1;
    logic               fstop_n_ff = 1'b1;
    logic               rstop_n_ff = 1'b1;

    // Clean registered levels stand in for tested outputs, no glitches
    always_ff @(posedge core_clk) begin
        req_n_ff   <= ~req;
        fstop_n_ff <= ~fstop;
        rstop_n_ff <= ~rstop;
    end
    // Both fixed stop lines idle high, never left floating
    assign request_in_n               = req_n_ff;
    assign controlled_first_stop_n    = fstop_n_ff;
    assign redundant_stop_and_clear_n = rstop_n_ff;
    // Pin readback; the bench breaks it to fake a wiring fault
    assign torque_ack_fb              = torque_removal_ack ^ fb_break;
endmodule : sio_ctrl_model

// ### sio_pkg.sv
// Constants, codes and register map of the safety signalling block
package sio_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_REQ   = 7;   // General request inputs
    localparam int NUM_STAT  = 4;   // General status outputs
    localparam int NUM_FUNC  = 9;   // Activation signals
    localparam int MAP_W     = 4;   // Bits per input map field
    localparam int OSEL_W    = 2;   // Bits per output map field
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ        = 20000;  // 20 MHz core clock
    localparam int STARTUP_US     = 100;    // Self-start hold-off
    localparam int STARTUP_CYC    = STARTUP_US * CLK_KHZ / 1000;
    localparam int STARTUP_W      = 12;

    // ------------------------------------------------------------
    // Activation signal indices (map field codes)
    // ------------------------------------------------------------
    localparam logic [3:0] FN_SECOND_STOP = 4'h0;
    localparam logic [3:0] FN_OPER_STOP   = 4'h1;
    localparam logic [3:0] FN_SPEED_WIN   = 4'h2;
    localparam logic [3:0] FN_SPEED_CEIL  = 4'h3;
    localparam logic [3:0] FN_DIR_NEG     = 4'h4;
    localparam logic [3:0] FN_DIR_POS     = 4'h5;
    localparam logic [3:0] FN_INCR        = 4'h6;
    localparam logic [3:0] FN_POSN        = 4'h7;
    localparam logic [3:0] FN_BRAKE       = 4'h8;

    // Status output source codes
    localparam logic [1:0] OS_HALT  = 2'h0;
    localparam logic [1:0] OS_DIR   = 2'h1;
    localparam logic [1:0] OS_RANGE = 2'h2;
    localparam logic [1:0] OS_OFF   = 2'h3;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_IN_MAP   = 8'h04;
    localparam logic [7:0]  REG_OUT_MAP  = 8'h08;
    localparam logic [7:0]  REG_STATE    = 8'h0C;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h10;
    localparam logic [7:0]  REG_IRQ_MASK = 8'h14;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
    localparam logic [27:0] IN_MAP_RST   = 28'hFFF_FFFF;
    localparam logic [7:0]  OUT_MAP_RST  = 8'hFF;
    localparam int          CTRL_ROUTE   = 0;  // Second route enable

    // Interrupt status bit layout
    localparam int IRQ_FSTOP = 0;   // First stop requested
    localparam int IRQ_ERR   = 1;   // Error latched
    localparam int IRQ_FBERR = 2;   // Torque-off feedback fault
    localparam int IRQ_TRIG  = 3;   // Request edges, 7 bits up
    localparam int IRQ_W     = IRQ_TRIG + NUM_REQ;

    // Card operating state
    typedef enum logic [1:0] {
        SIO_START,
        SIO_RUN,
        SIO_STOP,
        SIO_OFF
    } sio_state_e;

endpackage : sio_pkg

// ### tb_safety_io_status_logic.sv
// Self-checking bench for the safety signalling core
`timescale 1ns/1ps
module tb_safety_io_status_logic
    import sio_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                core_clk = 1'b0;
    logic                rst = 1'b1;
    logic [ADDR_W-1:0]   reg_addr = '0;
    logic [DATA_W-1:0]   reg_wdata = '0;
    logic                reg_we = 1'b0, reg_re = 1'b0, supply_ok = 1'b1, major_err = 1'b0;
    logic                internal_err = 1'b0, limit_exceeded = 1'b0, ramp_done = 1'b0;
    logic                standstill_ok = 1'b0, direction_ok = 1'b0, range_ok = 1'b0;
    logic                brake_cmd_in = 1'b0, fstop = 1'b0, rstop = 1'b0, fb_break = 1'b0;
    logic [NUM_REQ-1:0]  req = '0, request_in_n, func_trigger;
    logic [DATA_W-1:0]   reg_rdata;
    logic [NUM_FUNC-1:0] func_active;
    logic [NUM_STAT-1:0] status_out;
    logic                irq, controlled_first_stop_n, redundant_stop_and_clear_n;
    logic                torque_ack_fb, torque_removal_ack, second_shutdown_route, ready;
    logic                halt_ack, dir_ack, range_ack, pulse_disable, brake_cmd_out;
    int                  n_errors = 0, check_count = 0, trig_n = 0, cycles = 0;

    sio_core dut_u (.*);
    sio_ctrl_model ctrl_u (
        .core_clk, .req, .fstop, .rstop, .fb_break, .torque_removal_ack,
        .request_in_n, .controlled_first_stop_n, .redundant_stop_and_clear_n, .torque_ack_fb
    );

    // 50 ns period
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Trigger tally and hang guard; start-up alone takes 2000 cycles
    always @(posedge core_clk) begin
        trig_n += $countones(func_trigger);
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we    <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge core_clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re   <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, e);
    endtask : chk_reg
    // Redundant line low then high; ramp_done is left high so the stop completes
    task automatic clear_card;
        @(posedge core_clk);
        fstop        <= 1'b0;
        internal_err <= 1'b0;
        limit_exceeded <= 1'b0;
        rstop        <= 1'b1;
        cyc(6);
        @(posedge core_clk);
        rstop <= 1'b0;
        cyc(8);
    endtask : clear_card
    task automatic tally_and_finish;
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        cyc(1);
        chk(pulse_disable, 1);
        chk(ready, 0);
        chk_reg(REG_CTRL, CTRL_RST);
        chk_reg(REG_IN_MAP, {4'h0, IN_MAP_RST});
        chk_reg(REG_OUT_MAP, {24'h0, OUT_MAP_RST});
        chk_reg(REG_IRQ_MASK, 0);
        chk_reg(8'h20, 0);
        for (int k = 0; k < 2100 && ready !== 1'b1; k++) cyc(1);
        chk(ready, 1);
        chk(torque_removal_ack, 0);
        trig_n = 0;
        // Each of the nine codes in turn, on inputs 0..6 then 0 and 1 again
        for (int c = 0; c < NUM_FUNC; c++) begin
            int s;
            s = 4 * (c % NUM_REQ);
            wr(REG_IN_MAP, (32'h0FFF_FFFF & ~(32'hF << s)) | (c << s));
            @(posedge core_clk);
            req <= 7'h01 << (c % NUM_REQ);
            cyc(8);
            chk(func_active, 32'h1 << c);
            chk(trig_n, 1);
            @(posedge core_clk);
            req <= '0;
            cyc(8);
            chk(func_active, 0);
            trig_n = 0;
        end
        // Second stop, speed window and negative direction on inputs 0..2
        wr(REG_IN_MAP, 32'h0FFF_F420);
        wr(REG_OUT_MAP, 32'hE4);
        @(posedge core_clk);
        req           <= 7'h07;
        standstill_ok <= 1'b1;
        direction_ok  <= 1'b1;
        range_ok      <= 1'b1;
        brake_cmd_in  <= 1'b1;
        cyc(8);
        chk({halt_ack, dir_ack, range_ack}, 3'h7);
        chk(status_out, 4'h7);
        chk(brake_cmd_out, 1);
        @(posedge core_clk);
        range_ok <= 1'b0;
        cyc(6);
        chk(status_out, 4'h3);
        @(posedge core_clk);
        range_ok <= 1'b1;
        req      <= '0;
        cyc(8);
        chk({halt_ack, dir_ack, range_ack}, 0);
        wr(REG_CTRL, 0);
        cyc(3);
        chk(second_shutdown_route, 0);
        wr(REG_CTRL, 1);
        cyc(3);
        chk(second_shutdown_route, 1);
        // First stop beats a pending request, then ramps to power off
        wr(REG_IRQ_MASK, 32'h1);
        @(posedge core_clk);
        req   <= 7'h01;
        fstop <= 1'b1;
        cyc(8);
        chk(func_active, 0);
        chk(torque_removal_ack, 0);
        chk(irq, 1);
        chk_reg(REG_STATE, 32'h3400);
        wr(REG_IRQ_MASK, 0);
        cyc(1);
        chk(irq, 0);
        @(posedge core_clk);
        ramp_done <= 1'b1;
        req       <= '0;
        cyc(6);
        chk(torque_removal_ack, 1);
        clear_card();
        chk(torque_removal_ack, 0);
        wr(REG_IRQ_STAT, 32'h3FF);
        chk_reg(REG_IRQ_STAT, 0);
        @(posedge core_clk);
        internal_err <= 1'b1;
        cyc(6);
        chk(pulse_disable, 1);
        chk_reg(REG_IRQ_STAT, 32'h2);
        clear_card();
        chk(ready, 1);
        @(posedge core_clk);
        limit_exceeded <= 1'b1;
        cyc(6);
        chk(torque_removal_ack, 1);
        clear_card();
        // One broken readback cycle
        @(posedge core_clk);
        fb_break <= 1'b1;
        @(posedge core_clk);
        fb_break <= 1'b0;
        cyc(6);
        chk(ready, 0);
        clear_card();
        chk(ready, 1);
        @(posedge core_clk);
        major_err <= 1'b1;
        cyc(6);
        chk(ready, 0);
        @(posedge core_clk);
        major_err <= 1'b0;
        supply_ok <= 1'b0;
        cyc(6);
        chk(ready, 0);
        tally_and_finish();
    end
endmodule : tb_safety_io_status_logic
